// ---- core/bic_chan_if.sv ----
interface bic_chan_if;
   logic sample_en;
   logic raw;
   logic [7:0] dgl_len;
   logic [7:0] dbn_len;
   logic cnt_clr;
   logic level;
   logic change;
   logic [31:0] count;

   modport ctl (
      output sample_en, raw, dgl_len, dbn_len, cnt_clr,
      input level, change, count
   );
   modport chan (
      input sample_en, raw, dgl_len, dbn_len, cnt_clr,
      output level, change, count
   );
endinterface : bic_chan_if

// ---- core/bic_channel.sv ----
module bic_channel (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // settings in, conditioned level and count out
   bic_chan_if.chan ch
);

   bic_pkg::bic_chan_state_t q_r;
   bic_pkg::bic_chan_state_t q_nxt;

   always_comb begin
      q_nxt = q_r;
      q_nxt.change = 1'b0;
      if (ch.cnt_clr) begin
         q_nxt.count = '0;
      end
      if (ch.sample_en) begin // [RULE9]
         if (ch.dgl_len == 8'h00) begin
            q_nxt.dgl_out = ch.raw; // [RULE2] [RULE14]
            q_nxt.dgl_cnt = '0;
         end else if (ch.raw == q_r.dgl_out) begin
            // any sample back at the old level restarts qualification
            q_nxt.dgl_cnt = '0; // [RULE3]
         end else if (q_r.dgl_cnt >= ch.dgl_len) begin
            q_nxt.dgl_out = ch.raw; // [RULE3] [RULE4]
            q_nxt.dgl_cnt = '0;
         end else begin
            q_nxt.dgl_cnt = q_r.dgl_cnt + 8'h01;
         end
         // debounce looks at this sample's deglitched level
         if (q_r.dbn_hold != 8'h00) begin
            q_nxt.dbn_hold = q_r.dbn_hold - 8'h01; // [RULE6]
         end else if (q_nxt.dgl_out != q_r.dbn_out) begin // [RULE8]
            q_nxt.dbn_out = q_nxt.dgl_out; // [RULE5] [RULE7]
            q_nxt.dbn_hold = (ch.dbn_len == 8'h00) ? 8'h00 :
               ch.dbn_len - 8'h01; // [RULE6] [RULE14]
            q_nxt.change = 1'b1;
            if (q_nxt.dgl_out) begin
               q_nxt.count = q_nxt.count + 32'h0000_0001; // [RULE13]
            end
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         q_r <= '0;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign ch.level = q_r.dbn_out;
   assign ch.change = q_r.change;
   assign ch.count = q_r.count;

endmodule : bic_channel

// ---- core/bic_conditioner.sv ----
// Our own choices: the AHB-Lite register port and the address map.
`include "bic_params.svh"

// Function
// (RULE1) six binary channels, each sampled, deglitched, debounced, counted
// (RULE2) per-input deglitch time from zero to 25 ms; zero bypasses
// (RULE3) deglitch accepts a level only after it held the whole time
// (RULE4) accepted deglitch transitions lag the raw input by deglitch time
// (RULE5) debounce passes the first input change through at once
// (RULE6) after a change debounce holds output for debounce time
// (RULE7) after hold ends output follows input; a difference starts new hold
// (RULE8) debounce works on the deglitched signal of its channel
// (RULE9) both stages run on 10 kHz samples, 100 us resolution
// (RULE10) per-input counting up to 3 kHz, phases over 150 us
// (RULE11) two fast counter inputs count pulses up to 100 kHz
// (RULE12) fast counter source holds each phase longer than 3 us
// (RULE13) counters add one per rising edge, 32 bits, wrap, reset clears
// (RULE14) filter times are whole 100 us samples; zero disables stage
module bic_conditioner #(
   parameter int SAMPLE_DIV = `BIC_SAMPLE_DIV
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // input pins
   input wire logic [bic_pkg::NUM_BIN-1:0] bin_in,
   input wire logic [bic_pkg::NUM_HF-1:0] hf_in,
   // results
   output logic [bic_pkg::NUM_BIN-1:0] cond_level,
   output logic irq
);

   localparam int NB = bic_pkg::NUM_BIN;
   localparam int NH = bic_pkg::NUM_HF;
   localparam int NE = bic_pkg::NUM_EVT;

   bic_pkg::bic_top_state_t s_r;
   bic_pkg::bic_top_state_t s_nxt;

   logic [NB-1:0][31:0] bcnt;
   logic [NB-1:0] blvl;
   logic [NB-1:0] bchg;

   // settings beyond 25 ms are cut to the longest documented time
   function automatic logic [7:0] clamp_len(input logic [7:0] v);
      if (v > 8'(`BIC_MAX_FILTER_SAMPLES)) begin
         return 8'(`BIC_MAX_FILTER_SAMPLES); // [RULE2]
      end
      return v;
   endfunction : clamp_len

   // true inside a 32-byte window holding n word registers
   function automatic logic win_hit(
      input logic [7:0] a,
      input logic [7:0] base,
      input int n
   );
      return (a[7:5] == base[7:5]) && (a[4:2] < 3'(n));
   endfunction : win_hit

   function automatic logic [31:0] rd_word(input logic [7:0] a);
      logic [31:0] d;
      d = 32'h0000_0000;
      if (a[7:2] == `BIC_OFS_LEVEL >> 2) begin
         d[NB-1:0] = s_r.cond;
         d[`BIC_LEVEL_RAW_LSB +: NB] = s_r.bin_lvl;
      end else if (a[7:2] == `BIC_OFS_IRQ_STATUS >> 2) begin
         d[NE-1:0] = s_r.irq_st;
      end else if (a[7:2] == `BIC_OFS_IRQ_ENABLE >> 2) begin
         d[NE-1:0] = s_r.irq_en;
      end else if (win_hit(a, `BIC_OFS_CFG0, NB)) begin
         d[15:0] = s_r.cfg[a[4:2]];
      end else if (win_hit(a, `BIC_OFS_BCNT0, NB)) begin
         d = bcnt[a[4:2]];
      end else if (win_hit(a, `BIC_OFS_HCNT0, NH)) begin
         d = s_r.hf_cnt[a[2]];
      end
      return d;
   endfunction : rd_word

   always_comb begin
      logic [NE-1:0] evt;
      logic [NE-1:0] clr;
      logic [7:0] dgl;
      logic [7:0] dbn;
      evt = '0;
      clr = '0;
      dgl = 8'h00;
      dbn = 8'h00;
      s_nxt = s_r;

      // sample strobe divider
      s_nxt.sample_en = 1'b0;
      if (s_r.pre == 10'(SAMPLE_DIV - 1)) begin
         s_nxt.pre = '0;
         s_nxt.sample_en = 1'b1; // [RULE9]
      end else begin
         s_nxt.pre = s_r.pre + 10'h001;
      end

      // pin synchronisers: stage 0 feeds only stage 1
      for (int i = 0; i < NB; i++) begin
         s_nxt.bin_sync[i] = {s_r.bin_sync[i][1:0], bin_in[i]};
         if (s_r.bin_sync[i][1] == s_r.bin_sync[i][2]) begin
            s_nxt.bin_lvl[i] = s_r.bin_sync[i][2];
         end
      end

      // fast counters run at full clock rate, not the sample rate,
      // so 3 us phases (30 clocks) are resolved
      s_nxt.cnt_clr = '0;
      for (int j = 0; j < NH; j++) begin
         s_nxt.hf_sync[j] = {s_r.hf_sync[j][1:0], hf_in[j]};
         if (s_r.hf_sync[j][1] == s_r.hf_sync[j][2]) begin
            s_nxt.hf_lvl[j] = s_r.hf_sync[j][2];
         end
         if (s_r.cnt_clr[`BIC_IRQ_HF_LSB + j]) begin
            s_nxt.hf_cnt[j] = '0;
         end
         if (!s_r.hf_lvl[j] && s_nxt.hf_lvl[j]) begin // [RULE11] [RULE12]
            s_nxt.hf_cnt[j] = s_nxt.hf_cnt[j] + 32'h0000_0001; // [RULE13]
            if (s_nxt.hf_cnt[j] == 32'h0000_0000) begin
               evt[`BIC_IRQ_HF_LSB + j] = 1'b1;
            end
         end
      end

      // conditioned level and change events from the channels
      s_nxt.cond = blvl;
      evt[NB-1:0] = bchg;

      // ahb data phase: write lands one cycle after its address phase
      if (s_r.dp_wr) begin
         if (s_r.dp_addr[7:2] == `BIC_OFS_IRQ_CLEAR >> 2) begin
            clr = hwdata[NE-1:0];
         end else if (s_r.dp_addr[7:2] == `BIC_OFS_IRQ_ENABLE >> 2) begin
            s_nxt.irq_en = hwdata[NE-1:0];
         end else if (s_r.dp_addr[7:2] == `BIC_OFS_CNT_CLEAR >> 2) begin
            s_nxt.cnt_clr = hwdata[NE-1:0];
         end else if (win_hit(s_r.dp_addr, `BIC_OFS_CFG0, NB)) begin
            dgl = clamp_len(hwdata[`BIC_CFG_DGL_LSB +: 8]); // [RULE14]
            dbn = clamp_len(hwdata[`BIC_CFG_DBN_LSB +: 8]); // [RULE14]
            s_nxt.cfg[s_r.dp_addr[4:2]] = {dbn, dgl};
         end
      end

      // sticky status: a new event beats a clear in the same cycle
      s_nxt.irq_st = (s_r.irq_st & ~clr) | evt;
      s_nxt.irq = |(s_nxt.irq_st & s_nxt.irq_en);

      // ahb address phase; zero wait states, always okay
      s_nxt.hready = 1'b1;
      s_nxt.hresp = 1'b0;
      s_nxt.dp_wr = 1'b0;
      if (hsel && htrans[1] && hready) begin
         s_nxt.dp_wr = hwrite;
         s_nxt.dp_addr = haddr[7:0];
         if (!hwrite) begin
            s_nxt.hrdata = rd_word(haddr[7:0]);
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_r <= '0;
         s_r.hready <= 1'b1;
         s_r.irq_en <= `BIC_IRQ_EN_RST;
         for (int k = 0; k < NB; k++) begin
            s_r.cfg[k] <= `BIC_CFG_RST;
         end
      end else begin
         s_r <= s_nxt;
      end
   end

   // one conditioning path per binary input
   generate
      for (genvar g = 0; g < NB; g++) begin : g_chan // [RULE1]
         bic_chan_if ch_if ();

         assign ch_if.sample_en = s_r.sample_en;
         assign ch_if.raw = s_r.bin_lvl[g];
         assign ch_if.dgl_len = s_r.cfg[g][`BIC_CFG_DGL_LSB +: 8];
         assign ch_if.dbn_len = s_r.cfg[g][`BIC_CFG_DBN_LSB +: 8];
         assign ch_if.cnt_clr = s_r.cnt_clr[g];
         assign blvl[g] = ch_if.level;
         assign bchg[g] = ch_if.change;
         // 10 kHz sampling counts up to 3 kHz with 150 us phases
         assign bcnt[g] = ch_if.count; // [RULE10]

         bic_channel u_chan (
            .clk(clk),
            .sys_rst(sys_rst),
            .ch(ch_if.chan)
         );
      end
   endgenerate

   assign hreadyout = s_r.hready;
   assign hrdata = s_r.hrdata;
   assign hresp = s_r.hresp;
   assign cond_level = s_r.cond;
   assign irq = s_r.irq;

endmodule : bic_conditioner

// ---- core/bic_params.svh ----
`ifndef BIC_PARAMS_SVH
`define BIC_PARAMS_SVH

// clock and sample timing
`define BIC_CLK_MHZ 10
`define BIC_SAMPLE_PERIOD_US 100
`define BIC_SAMPLE_DIV (`BIC_CLK_MHZ * `BIC_SAMPLE_PERIOD_US)
`define BIC_MAX_FILTER_US 25000
`define BIC_MAX_FILTER_SAMPLES (`BIC_MAX_FILTER_US / `BIC_SAMPLE_PERIOD_US)

// register byte offsets
`define BIC_OFS_LEVEL 8'h00
`define BIC_OFS_IRQ_STATUS 8'h04
`define BIC_OFS_IRQ_CLEAR 8'h08
`define BIC_OFS_IRQ_ENABLE 8'h0C
`define BIC_OFS_CNT_CLEAR 8'h10
`define BIC_OFS_CFG0 8'h20
`define BIC_OFS_BCNT0 8'h40
`define BIC_OFS_HCNT0 8'h60

// field positions
`define BIC_CFG_DGL_LSB 0
`define BIC_CFG_DBN_LSB 8
`define BIC_LEVEL_RAW_LSB 8
`define BIC_IRQ_HF_LSB 6

// reset values
`define BIC_CFG_RST 16'h0000
`define BIC_IRQ_EN_RST 8'h00

`endif

// ---- core/bic_pkg.sv ----
package bic_pkg;

   localparam int NUM_BIN = 6;
   localparam int NUM_HF = 2;
   localparam int NUM_EVT = NUM_BIN + NUM_HF;

   typedef struct packed {
      logic dgl_out;
      logic [7:0] dgl_cnt;
      logic dbn_out;
      logic [7:0] dbn_hold;
      logic [31:0] count;
      logic change;
   } bic_chan_state_t;

   typedef struct packed {
      logic [9:0] pre;
      logic sample_en;
      logic [NUM_BIN-1:0][2:0] bin_sync;
      logic [NUM_BIN-1:0] bin_lvl;
      logic [NUM_HF-1:0][2:0] hf_sync;
      logic [NUM_HF-1:0] hf_lvl;
      logic [NUM_HF-1:0][31:0] hf_cnt;
      logic [NUM_BIN-1:0][15:0] cfg;
      logic [NUM_EVT-1:0] irq_st;
      logic [NUM_EVT-1:0] irq_en;
      logic [NUM_EVT-1:0] cnt_clr;
      logic irq;
      logic [NUM_BIN-1:0] cond;
      logic dp_wr;
      logic [7:0] dp_addr;
      logic [31:0] hrdata;
      logic hready;
      logic hresp;
   } bic_top_state_t;

endpackage : bic_pkg

// ---- test/bic_asserts.sv ----
module bic_asserts #(
   parameter int SAMPLE_DIV = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // bus
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hresp,
   // pins and results
   input wire logic [bic_pkg::NUM_BIN-1:0] bin_in,
   input wire logic [bic_pkg::NUM_BIN-1:0] cond_level,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ns;
   // longest settle: 251 deglitch plus 250 hold samples, with margin
   localparam int LIM = 520 * SAMPLE_DIV;
   logic [15:0] gap_r;
   logic [15:0] stab_r;
   logic [15:0] wr_r;
   logic [5:0] bin_d_r;
   logic [5:0] lvl_d_r;
   logic rd_go;
   logic quiet;
   assign rd_go = hsel && htrans[1] && hready && !hwrite;
   assign quiet = stab_r >= LIM && bin_in == bin_d_r;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         gap_r <= 16'h0;
         stab_r <= 16'h0;
         wr_r <= 16'hFFFF;
         bin_d_r <= 6'h00;
         lvl_d_r <= 6'h00;
      end else begin
         gap_r <= (cond_level != lvl_d_r) ? 16'h0 : gap_r + {15'h0, ~&gap_r};
         stab_r <= (bin_in != bin_d_r) ? 16'h0 : stab_r + {15'h0, ~&stab_r};
         wr_r <= (hsel && htrans[1] && hready && hwrite) ? 16'h0 :
            wr_r + {15'h0, ~&wr_r};
         bin_d_r <= bin_in;
         lvl_d_r <= cond_level;
      end
   end
   default clocking @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   chk_resp_okay:
      assert property (hresp == 1'b0)
      else $error("response not okay");
   chk_rd_hold:
      assert property (!rd_go |=> $stable(hrdata))
      else $error("read data moved without a read");
   chk_reset_clear:
      assert property ($fell(sys_rst) |-> cond_level == 6'h00 && !irq)
      else $error("outputs not clear after reset");
   chk_level_gap:
      assert property (cond_level != lvl_d_r |-> gap_r >= SAMPLE_DIV - 1)
      else $error("level changed between samples");
   chk_level_follow:
      assert property (quiet |-> cond_level == bin_in)
      else $error("level not following settled input");
   chk_level_quiet:
      assert property (quiet |=> $stable(cond_level))
      else $error("level moved on settled input");
   chk_irq_fall:
      assert property ($fell(irq) |-> wr_r <= 16'h4)
      else $error("interrupt dropped without a write");
   chk_irq_rise:
      assert property ($rose(irq) |->
         wr_r <= 16'h4 || gap_r <= 16'h3 || cond_level != lvl_d_r)
      else $error("interrupt rose without a cause");
   cover property ($rose(irq));
   cover property ($fell(irq));
   cover property (cond_level != lvl_d_r);
endmodule : bic_asserts

bind bic_conditioner bic_asserts #(.SAMPLE_DIV(SAMPLE_DIV)) u_chk (.*);

// ---- test/bic_source.sv ----
module bic_source (
   // clock
   input wire logic clk,
   // pins of the block
   output logic [5:0] bin_in,
   output logic [1:0] hf_in
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      bin_in = 6'h00;
      hf_in = 2'h0;
   end
   // called just after a rising edge, so levels move on the edge
   task automatic drv(input bit hf, input int ch, input logic v);
      if (hf)
         hf_in[ch] <= v;
      else
         bin_in[ch] <= v;
   endtask : drv
   // callers pick ph; some test calls pick it below the deglitch time so the pulse is filtered
   task automatic pulses(input bit hf, input int ch, n, ph);
      repeat (n) begin
         drv(hf, ch, 1'b1);
         repeat (ph) @(posedge clk);
         drv(hf, ch, 1'b0);
         repeat (ph) @(posedge clk);
      end
   endtask : pulses
endmodule : bic_source

// ---- test/binary_input_conditioner_test.sv ----
module binary_input_conditioner_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int D = 8;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic [31:0] q;
   logic hrdy;
   logic hresp;
   logic irq;
   logic [5:0] bin_in;
   logic [5:0] cond_level;
   logic [1:0] hf_in;
   int mismatches = 0;
   int num_checks = 0;
   always #50 clk = ~clk;
   bic_source src (.clk(clk), .bin_in(bin_in), .hf_in(hf_in));
   bic_conditioner #(.SAMPLE_DIV(D)) dut (
      .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hrdy),
      .hreadyout(hrdy), .hrdata(hrdata), .hresp(hresp), .bin_in(bin_in),
      .hf_in(hf_in), .cond_level(cond_level), .irq(irq));
   task automatic end_sim;
      $display("checks %0d, mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic hold;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hrdy !== 1'b1 && n < 64);
      if (hrdy !== 1'b1) begin
         mismatches++;
         $display("wrong value at %0t: bus wait timed out", $time);
         end_sim();
      end
   endtask : hold
   task automatic bus(input logic w, input logic [31:0] a, d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      hold();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      hold();
      q = hrdata;
   endtask : bus
   task automatic bw(input logic [31:0] a, d);
      bus(1'b1, a, d);
   endtask : bw
   task automatic rc(input logic [31:0] a, e);
      bus(1'b0, a, 32'h0);
      chk(q, e);
   endtask : rc
   // sampled mid-cycle so the edge's own updates have landed
   task automatic pins(input int n, input logic [31:0] e);
      repeat (n) @(posedge clk);
      @(negedge clk);
      chk({25'h0, irq, cond_level}, e);
      @(posedge clk);
   endtask : pins
   initial begin
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      rc(32'h20, 32'h0);
      rc(32'h0C, 32'h0);
      bw(32'h1C, 32'hFFFFFFFF);
      rc(32'h1C, 32'h0);
      bw(32'h34, 32'hFFFF);
      rc(32'h34, 32'hFAFA);
      // channel 5 back to bypass, or its 25 ms filters stall the next checks
      bw(32'h34, 32'h0);
      for (int i = 0; i < 6; i++) src.drv(1'b0, i, 1'b1);
      pins(3 * D, 32'h3F);
      for (int i = 0; i < 6; i++) rc(32'h40 + 4 * i, 32'h1);
      rc(32'h04, 32'h3F);
      bw(32'h0C, 32'h1);
      pins(2, 32'h7F);
      bw(32'h08, 32'h1);
      pins(2, 32'h3F);
      rc(32'h04, 32'h3E);
      bw(32'h08, 32'hFF);
      bw(32'h0C, 32'h0);
      for (int i = 0; i < 6; i++) src.drv(1'b0, i, 1'b0);
      pins(3 * D, 32'h0);
      bw(32'h24, 32'h3);
      src.pulses(1'b0, 1, 1, 2 * D);
      pins(6 * D, 32'h0);
      src.drv(1'b0, 1, 1'b1);
      pins(3 * D, 32'h0);
      pins(2 * D, 32'h2);
      bw(32'h28, 32'h400);
      src.drv(1'b0, 2, 1'b1);
      pins(D + 6, 32'h6);
      src.drv(1'b0, 2, 1'b0);
      pins(2 * D, 32'h6);
      pins(3 * D, 32'h2);
      bw(32'h2C, 32'h402);
      src.pulses(1'b0, 3, 1, D);
      pins(4 * D, 32'h2);
      bw(32'h10, 32'h10);
      src.pulses(1'b0, 4, 5, 2 * D);
      rc(32'h50, 32'h5);
      src.pulses(1'b1, 0, 7, 50);
      src.pulses(1'b1, 1, 3, 50);
      rc(32'h60, 32'h7);
      rc(32'h64, 32'h3);
      pins(600 * D, 32'h2);
      end_sim();
   end
endmodule : binary_input_conditioner_test
